// ==== hw/clc_pkg.sv ====
// How it works
// [R1] Register 00h charge voltage, default A0h
// [R2] Charge voltage code: 6.80 V plus 10 mV
// [R3] Register 01h: bit7 hi-Z, bit6 pin-limit
// [R4] High-impedance enable resets to zero
// [R5] Pin current-limit enable defaults to one
// [R6] Fast charge code bits 5:0, 50 mA
// [R7] Fast charge code clamped 100..2200 mA
// [R8] Register 02h default 85h, split restore
// [R9] Autoreload bit restores input limit field
// [R10] Bit6 of 02h switches discharge load
// [R11] Bit5 of 02h suppresses out-of-audio
// [R12] Input limit code: 3.9 V plus 100 mV
// [R13] Input limit codes above 10h clamp
// [R14] Watchdog expiry restores watchdog-reset fields
// [R15] Undefined register offset gets NACK, idle
// [R16] Reads return stored bits, not clamped
// [R17] Detection-done pulse triggers input-limit reload
package clc_pkg;
	// Serial port slave address
	localparam logic [6:0] SLAVE_ADDR = 7'h6b;
	// Register offsets and count
	localparam logic [7:0] OFS_VOLT = 8'h00;
	localparam logic [7:0] OFS_CURR = 8'h01;
	localparam logic [7:0] OFS_VIN = 8'h02;
	localparam logic [7:0] REG_COUNT = 8'h03;
	// Reset values
	localparam logic [7:0] VOLT_RST = 8'ha0;
	localparam logic [7:0] CURR_RST = 8'h54;
	localparam logic [7:0] VIN_RST = 8'h85;
	// Field positions
	localparam int HI_IMP_BIT = 7;
	localparam int PINLIM_BIT = 6;
	localparam int RELOAD_BIT = 7;
	localparam int DISCHG_BIT = 6;
	localparam int OOA_BIT = 5;
	// Saturation limits of the regulation targets
	localparam logic [5:0] FAST_CODE_MAX = 6'h2c;
	localparam logic [5:0] FAST_CODE_MIN = 6'h02;
	localparam logic [4:0] VIN_MAX = 5'h10;
	// Bit counts on the serial port
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;

	// Serial port states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_REG,
		ST_WDATA,
		ST_ACK,
		ST_RDATA,
		ST_MACK
	} clc_st_t;

	// Regulation targets handed to the analog side
	typedef struct packed {
		logic [7:0] charge_voltage_code;
		logic high_impedance_enable;
		logic current_pin_limit_enable;
		logic [5:0] fast_charge_current_code;
		logic input_voltage_limit_autoreload;
		logic battery_discharge_load_enable;
		logic out_of_audio_disable;
		logic [4:0] input_voltage_limit_code;
	} clc_cfg_t;

	// Whole state of the block
	typedef struct packed {
		clc_st_t st;
		clc_st_t nx;
		logic scl_p;
		logic sda_p;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic [7:0] ptr;
		logic oe;
		logic [7:0] volt;
		logic [7:0] curr;
		logic [7:0] vin;
		clc_cfg_t cfg;
	} clc_state_t;

	localparam clc_cfg_t CFG_RST = '{VOLT_RST, 1'b0, 1'b1, 6'h14, 1'b1, 1'b0, 1'b0, 5'h05};
	localparam clc_state_t STATE_RST = '{ST_IDLE, ST_IDLE, 1'b1, 1'b1, 8'h00, 4'h0, 8'h00, 1'b0,
		VOLT_RST, CURR_RST, VIN_RST, CFG_RST};
endpackage

// ==== hw/clc_regs.sv ====
`timescale 1ns/100ps
module clc_regs import clc_pkg::*; (
	input wire logic ref_clk_i, // 40 MHz clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic scl_i, // Serial clock from host
	input wire logic sda_i, // Serial data line level
	output logic sda_o, // Serial data drive value
	output logic sda_oe_o, // High while pulling data low
	input wire logic soft_reset_i, // Register soft reset pulse
	input wire logic wdog_expire_i, // Watchdog expiry pulse
	input wire logic detect_done_i, // Source detection done pulse
	output clc_cfg_t cfg_o // Saturated regulation targets
);
	clc_state_t q, d; // Registered state and its next value
	logic rise, fall, start, stop; // Bus events

	// Read decode, used when loading any read byte
	function automatic logic [7:0] rd_byte(input clc_state_t s, input logic [7:0] a);
		case (a)
			OFS_VOLT: rd_byte = s.volt; // R16
			OFS_CURR: rd_byte = s.curr;
			OFS_VIN: rd_byte = s.vin;
			default: rd_byte = 8'h00; // Past the map reads zero
		endcase
	endfunction

	// Bus edge and condition detection
	always_comb begin
		rise = scl_i & ~q.scl_p;
		fall = ~scl_i & q.scl_p;
		start = scl_i & q.scl_p & q.sda_p & ~sda_i;
		stop = scl_i & q.scl_p & ~q.sda_p & sda_i;
	end

	// Next state: serial port, then register events, then targets
	always_comb begin
		d = q;
		d.scl_p = scl_i;
		d.sda_p = sda_i;
		if (start) begin
			// Start or repeated start always restarts the address phase
			d.st = ST_ADDR;
			d.cnt = 4'h0;
			d.oe = 1'b0;
		end else if (stop) begin
			d.st = ST_IDLE;
			d.oe = 1'b0;
		end else begin
			case (q.st)
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (rise && q.cnt < BYTE_BITS) begin
						// Shift in, MSB first
						d.sh = {q.sh[6:0], sda_i};
						d.cnt = 4'(q.cnt + 4'h1);
					end else if (fall && q.cnt == BYTE_BITS) begin
						d.cnt = 4'h0;
						d.st = ST_ACK;
						d.oe = 1'b1;
						if (q.st == ST_ADDR) begin
							// Foreign address: stay off the bus
							if (q.sh[7:1] != SLAVE_ADDR) begin
								d.st = ST_IDLE;
								d.oe = 1'b0;
							end
							d.nx = q.sh[0] ? ST_RDATA : ST_REG;
						end else if (q.st == ST_REG) begin
							d.ptr = q.sh;
							d.nx = ST_WDATA;
							if (q.sh >= REG_COUNT) begin
								d.st = ST_IDLE; // R15
								d.oe = 1'b0;
							end
						end else begin
							// Data write with auto-increment for multi-write
							d.nx = ST_WDATA;
							d.ptr = 8'(q.ptr + 8'h01);
							case (q.ptr)
								OFS_VOLT: d.volt = q.sh; // R1
								OFS_CURR: d.curr = q.sh; // R3
								OFS_VIN: d.vin = q.sh; // R8
								default: begin
									d.st = ST_IDLE; // R15
									d.oe = 1'b0;
								end
							endcase
						end
					end
				end
				ST_ACK, ST_MACK: begin
					// Host NACK on a read ends the transfer
					if (q.st == ST_MACK && rise && sda_i) begin
						d.st = ST_IDLE;
					end else if (fall) begin
						d.st = q.nx;
						d.oe = 1'b0;
						if (q.nx == ST_RDATA || q.st == ST_MACK) begin
							d.st = ST_RDATA;
							d.sh = rd_byte(q, q.ptr); // R16
							// Bit count restarts per byte, else a second read byte ends early
							d.cnt = 4'h0;
							d.oe = ~d.sh[7];
							d.ptr = 8'(q.ptr + 8'h01);
						end
					end
				end
				ST_RDATA: begin
					// Change data on the falling edge, host samples on rise
					if (fall) begin
						if (q.cnt == LAST_BIT) begin
							d.st = ST_MACK;
							d.oe = 1'b0;
						end else begin
							d.sh = {q.sh[6:0], 1'b0};
							d.oe = ~q.sh[6];
							d.cnt = 4'(q.cnt + 4'h1);
						end
					end
				end
				default: d.st = ST_IDLE;
			endcase
		end
		// Resets act after a same-cycle write, so they win over it
		if (soft_reset_i) begin
			d.volt = VOLT_RST; // R1
			d.curr = CURR_RST; // R3
			d.vin = VIN_RST; // R8
		end else begin
			if (wdog_expire_i) begin
				// Low six bits of 02h survive the watchdog
				d.volt = VOLT_RST; // R14
				d.curr = CURR_RST; // R14
				d.vin[7:6] = VIN_RST[7:6]; // R8
			end
			if (detect_done_i && d.vin[RELOAD_BIT]) begin
				d.vin[4:0] = VIN_RST[4:0]; // R9 R17
			end
		end
		// Targets: clamp applied here only, stored bits untouched
		d.cfg.charge_voltage_code = q.volt; // R2
		d.cfg.high_impedance_enable = q.curr[HI_IMP_BIT]; // R4
		d.cfg.current_pin_limit_enable = q.curr[PINLIM_BIT]; // R5
		d.cfg.fast_charge_current_code = (q.curr[5:0] > FAST_CODE_MAX) ? FAST_CODE_MAX : // R6 R7
			(q.curr[5:0] < FAST_CODE_MIN) ? FAST_CODE_MIN : q.curr[5:0];
		d.cfg.input_voltage_limit_autoreload = q.vin[RELOAD_BIT];
		d.cfg.battery_discharge_load_enable = q.vin[DISCHG_BIT]; // R10
		d.cfg.out_of_audio_disable = q.vin[OOA_BIT]; // R11
		d.cfg.input_voltage_limit_code = (q.vin[4:0] > VIN_MAX) ? VIN_MAX : q.vin[4:0]; // R12 R13
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= STATE_RST;
		end else begin
			q <= d;
		end
	end

	// Open-drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = q.oe;
	assign cfg_o = q.cfg;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_reg_byte_done;
		q.st == ST_REG && fall && !start && !stop && q.cnt == BYTE_BITS;
	endsequence
	sequence s_bad_offset;
		s_reg_byte_done ##0 (q.sh >= REG_COUNT);
	endsequence

	a_bad_offset_nack: assert property (s_bad_offset |=> q.st == ST_IDLE && !sda_oe_o) // R15
		else $error("undefined offset was acknowledged");
	a_good_offset_ack: assert property (s_reg_byte_done ##0 (q.sh < REG_COUNT) |=> sda_oe_o ##1 q.ptr < REG_COUNT) // R15
		else $error("defined offset not acknowledged");
	a_soft_all_default: assert property (soft_reset_i |=> q.volt == 8'ha0 && q.curr == 8'h54 && q.vin == 8'h85) // R1 R3 R8
		else $error("soft reset left a register off default");
	a_wdog_split_restore: assert property (wdog_expire_i && !soft_reset_i && !detect_done_i && q.st != ST_WDATA
		|=> q.volt == 8'ha0 && q.curr == 8'h54 && q.vin[7:6] == 2'b10 && q.vin[5:0] == $past(q.vin[5:0])) // R14 R8
		else $error("watchdog restore wrong");
	a_reload_on_detect: assert property (detect_done_i && q.vin[7] && !soft_reset_i && !wdog_expire_i && q.st != ST_WDATA
		|=> q.vin[4:0] == 5'h05) // R9 R17
		else $error("input limit not reloaded");
	a_no_reload_off: assert property (detect_done_i && !q.vin[7] && !soft_reset_i && !wdog_expire_i && q.st != ST_WDATA
		|=> $stable(q.vin)) // R9
		else $error("input limit changed with reload off");
	a_fast_clamp_hi: assert property (q.curr[5:0] > 6'h2c |=> cfg_o.fast_charge_current_code == 6'h2c) // R7
		else $error("fast charge high clamp missing");
	a_fast_clamp_lo: assert property (q.curr[5:0] < 6'h02 |=> cfg_o.fast_charge_current_code == 6'h02) // R7
		else $error("fast charge low clamp missing");
	a_vin_clamp: assert property (q.vin[4:0] > 5'h10 |=> cfg_o.input_voltage_limit_code == 5'h10) // R13
		else $error("input limit clamp missing");
	a_mode_bits_follow: assert property (##1 cfg_o.high_impedance_enable == $past(q.curr[7])
		&& cfg_o.battery_discharge_load_enable == $past(q.vin[6]) && cfg_o.out_of_audio_disable == $past(q.vin[5])) // R4 R10 R11
		else $error("mode bit target mismatch");
endmodule

// ==== testbench/charger_limit_config_regs_tb_top.sv ====
`timescale 1ns/100ps
module charger_limit_config_regs_tb_top import clc_pkg::*;;
	logic ref_clk_i = 1'b0; // 40 MHz clock
	logic rst_n_i = 1'b0; // Reset, active low
	logic [2:0] ev = 3'h0; // Soft reset, watchdog, detect done
	logic scl; // Host clock
	logic host_sda; // Host data release
	logic sda_oe; // Slave pulls low
	logic sda_val; // Slave drive value while enabled
	logic sda_line; // Wire level
	clc_cfg_t cfg; // Regulation targets
	int err_count = 0;
	int total_checks = 0;
	assign sda_line = host_sda & (~sda_oe | sda_val); // Open drain, pull-up
	always #12.5 ref_clk_i = ~ref_clk_i;
	clc_regs u_clc_regs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_val), .sda_oe_o(sda_oe), .soft_reset_i(ev[2]), .wdog_expire_i(ev[1]),
		.detect_done_i(ev[0]), .cfg_o(cfg));
	clc_i2c_host u_clc_i2c_host (.clk_i(ref_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(host_sda));
	// Targets from stored bits, with clamping
	function automatic clc_cfg_t exp_cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		exp_cfg = {a, b[7:6], (b[5:0] > 6'h2c) ? 6'h2c : ((b[5:0] < 6'h02) ? 6'h02 : b[5:0]),
			c[7:5], (c[4:0] > 5'h10) ? 5'h10 : c[4:0]};
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Byte out, slave acknowledge compared
	task automatic snd(input logic [7:0] d, input logic nack);
		logic [7:0] q;
		logic a;
		u_clc_i2c_host.xfer(d, 1'b1, q, a);
		check({23'h0, a}, {23'h0, nack});
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		u_clc_i2c_host.start();
		snd(8'hd6, 1'b0);
		snd(off, off > 8'h02);
		if (off <= 8'h02) snd(d, 1'b0);
		u_clc_i2c_host.stop();
	endtask
	// Multi-read of all three, then targets
	task automatic chk_all(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		logic [7:0] q [3];
		logic x;
		u_clc_i2c_host.start();
		snd(8'hd6, 1'b0);
		snd(8'h00, 1'b0);
		u_clc_i2c_host.start();
		snd(8'hd7, 1'b0);
		for (int i = 0; i < 3; i++) u_clc_i2c_host.xfer(8'hff, i == 2, q[i], x);
		u_clc_i2c_host.stop();
		check({16'h0, q[0]}, {16'h0, a});
		check({16'h0, q[1]}, {16'h0, b});
		check({16'h0, q[2]}, {16'h0, c});
		check(cfg, exp_cfg(a, b, c));
	endtask
	// One-cycle event pulse
	task automatic pulse(input logic [2:0] v);
		@(posedge ref_clk_i);
		ev <= v;
		@(posedge ref_clk_i);
		ev <= 3'h0;
		repeat (3) @(posedge ref_clk_i);
	endtask
	task automatic t_write();
		wr(8'h00, 8'h37);
		wr(8'h01, 8'hc1);
		u_clc_i2c_host.start();
		snd(8'hd6, 1'b0);
		snd(8'h02, 1'b0);
		snd(8'h7f, 1'b0);
		snd(8'h55, 1'b1);
		u_clc_i2c_host.stop();
		chk_all(8'h37, 8'hc1, 8'h7f);
		wr(8'h01, 8'h3f);
		wr(8'h03, 8'h00);
		chk_all(8'h37, 8'h3f, 8'h7f);
		$display("test write done");
	endtask
	// Watchdog keeps 02h[5:0], then reload
	task automatic t_events();
		pulse(3'b010);
		chk_all(8'ha0, 8'h54, 8'hbf);
		pulse(3'b001);
		chk_all(8'ha0, 8'h54, 8'ha5);
		wr(8'h02, 8'h1a);
		pulse(3'b001);
		chk_all(8'ha0, 8'h54, 8'h1a);
		pulse(3'b100);
		chk_all(8'ha0, 8'h54, 8'h85);
		$display("test events done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		chk_all(8'ha0, 8'h54, 8'h85);
		$display("test reset done");
		t_write();
		t_events();
		print_verdict();
	end
	// Watchdog, well past the expected run
	initial begin
		repeat (50000) @(posedge ref_clk_i);
		err_count++;
		print_verdict();
	end
endmodule

// ==== testbench/clc_i2c_host.sv ====
`timescale 1ns/100ps
// Serial host; each level held four clocks, above the one the slave needs
module clc_i2c_host (
	input wire logic clk_i, // Reference clock
	input wire logic sda_line_i, // Resolved data line
	output logic scl_o, // Serial clock
	output logic sda_o // 1 releases to pull-up
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// One clock level
	task automatic hold();
		repeat (4) @(posedge clk_i);
	endtask
	// Start, also repeated start
	task automatic start();
		sda_o <= 1'b1;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_o <= 1'b0;
		hold();
		scl_o <= 1'b0;
		hold();
	endtask
	// Data rises while clock high
	task automatic stop();
		sda_o <= 1'b0;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_o <= 1'b1;
		hold();
	endtask
	// Eight bits MSB first, then acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		logic [8:0] v;
		logic [8:0] r;
		v = {d, ack_in};
		for (int i = 8; i >= 0; i--) begin
			sda_o <= v[i];
			hold();
			scl_o <= 1'b1;
			hold();
			r[i] = sda_line_i;
			scl_o <= 1'b0;
			hold();
		end
		q = r[8:1];
		ack = r[0];
	endtask
endmodule
